//--- hdl/ocr_ctrl.v
`include "ocr_defines.vh"

// Summary of operation
// R1: present flag set while current limit engaged and thermal timer charging.
// R2: timer threshold sets latched fault flag and drives gate off.
// R3: present flag clears once the gate is off.
// R4: nonzero retry field lets gate return only after cooling delay.
// R5: cooling delay selectable 512ms to 65.5s in doubling steps.
// R6: delay-running flag is one for the whole cooling delay.
// R7: retry field selects one, seven or unlimited retries.
// R8: finite retries start a counter reset timer at each retry.
// R9: fault before expiry increments counter and restarts; expiry clears counter.
// R10: retries used up plus fault before expiry latches gate off.
// R11: reset timer held disabled while power good is not met.
// R12: overcurrent retry counter and timer are private to this block.
// R13: retry field zero keeps gate off until fault flag reset, then delay.
// R14: limit sense voltage set in 1mV steps from 15mV to 30mV.
// R15: limit configuration loads power-on defaults from stored copy.
// R16: fast pull-down threshold is always twice the limit sense voltage.
// R17: host may keep copper resistance in free nonvolatile scratch area (no scratch area in this block; address E9 reads zero).
// R18: foldback floor selects 10, 20, 50 or 100 percent.
// R19: startup uses flat foldback at the floor.
// R20: normal mode ratio rises linearly from floor to full at knee.
// R21: load power foldback falls linearly to half at maximum voltage.
// R22: foldback disable acts only in normal mode, not on load power foldback.
// R23: unlimited retry never latches off and retries after each delay.
module ocr_ctrl #(
  parameter [31:0] COOL_BASE_CYCLES   = `OCR_COOL_BASE_CYCLES,
  parameter [31:0] RESET_TIMER_CYCLES = `OCR_RESET_TIMER_CYCLES
) (
  input  wire        clock,
  input  wire        srst,
  input  wire        gate_on_request,
  input  wire        current_limit_active,
  input  wire        thermal_timer_charging,
  input  wire        thermal_timer_tripped,
  input  wire        power_good_latched,
  input  wire [7:0]  attenuated_drain_sense,
  input  wire [7:0]  reg_addr,
  input  wire        reg_write,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_read,
  output reg  [7:0]  reg_rdata,
  output wire        gate_drive,
  output reg  [12:0] limit_sense_voltage,
  output reg  [5:0]  fast_pulldown_threshold
);

  localparam [1:0] ST_ON      = 2'h0;
  localparam [1:0] ST_COOL    = 2'h1;
  localparam [1:0] ST_LATCHED = 2'h2;

  // cooldown length for a selector, doubling per step
  function [31:0] cool_cycles;
    input [2:0] sel;
    begin
      cool_cycles = COOL_BASE_CYCLES << sel;
    end
  endfunction

  // floor ratio for a selector
  function [7:0] floor_ratio;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    floor_ratio = `OCR_RATIO_10PCT;
        2'h1:    floor_ratio = `OCR_RATIO_20PCT;
        2'h2:    floor_ratio = `OCR_RATIO_50PCT;
        default: floor_ratio = `OCR_RATIO_FULL;
      endcase
    end
  endfunction

  // foldback ratio from mode, settings and output voltage code
  function [7:0] fold_ratio;
    input [7:0] volt;
    input [7:0] floor_val;
    input       normal_mode;
    input       fold_off;
    input       load_fold;
    reg   [15:0] rise;
    reg   [7:0]  drop;
    begin
      rise = 16'h0000;
      drop = 8'h00;
      if (!normal_mode)
        fold_ratio = floor_val;                                  // [R19]
      else if (volt < `OCR_KNEE_CODE)
      begin
        if (fold_off)
          fold_ratio = `OCR_RATIO_FULL;                          // [R22]
        else
        begin
          rise = (`OCR_RATIO_FULL - floor_val) * volt;
          fold_ratio = floor_val + rise[14:7];                   // [R20]
        end
      end
      else if (load_fold)
      begin
        drop = (volt - `OCR_KNEE_CODE + 8'h01) >> 1;
        fold_ratio = `OCR_RATIO_FULL - drop;                     // [R21] [R22]
      end
      else
        fold_ratio = `OCR_RATIO_FULL;
    end
  endfunction

  // pin inputs, two flops each
  reg  [4:0] sync_a;
  reg  [4:0] sync_b;
  reg  [7:0] volt_a;
  reg  [7:0] volt_b;
  wire       on_req   = sync_b[0];
  wire       cl_act   = sync_b[1];
  wire       chg_in   = sync_b[2];
  wire       trip_in  = sync_b[3];
  wire       pg       = sync_b[4];

  always @(posedge clock)
  begin
    if (srst)
    begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
      volt_a <= 8'h00;
      volt_b <= 8'h00;
    end
    else
    begin
      sync_a <= {power_good_latched, thermal_timer_tripped, thermal_timer_charging,
                 current_limit_active, gate_on_request};
      sync_b <= sync_a;
      volt_a <= attenuated_drain_sense;
      volt_b <= volt_a;
    end
  end

  // registers
  reg  [7:0] retry_policy_control;
  reg  [7:0] limit_foldback_setup;
  reg  [7:0] delay_threshold_setup;
  reg  [7:0] restart_delay_control;
  reg  [7:0] stored_limit_defaults;
  reg        defaults_pending;
  reg        overcurrent_latched_flag;
  reg        overcurrent_present_flag;

  reg  [1:0] state;
  reg  [1:0] next_state;
  reg  [2:0] retries_used;
  reg  [2:0] next_retries_used;

  wire       cool_running;
  wire       cool_expired;
  wire       rst_running;
  wire       rst_expired;

  wire [1:0] overcurrent_retry_count_sel = retry_policy_control[`OCR_RETRY_SEL_LSB +: 2];
  wire [2:0] cooldown_duration_sel      = delay_threshold_setup[`OCR_COOL_SEL_LSB +: 3];
  wire [3:0] limit_sense_setting        = limit_foldback_setup[`OCR_LIMIT_SET_LSB +: 4];
  wire [1:0] foldback_floor_sel         = limit_foldback_setup[`OCR_FLOOR_SEL_LSB +: 2];
  wire       normal_foldback_disable    = limit_foldback_setup[`OCR_BIT_FOLD_OFF];
  wire       load_power_foldback_enable = limit_foldback_setup[`OCR_BIT_LOAD_FOLD];

  wire       finite_retry = (overcurrent_retry_count_sel == `OCR_RETRY_ONE) ||
                            (overcurrent_retry_count_sel == `OCR_RETRY_SEVEN);   // [R7]
  wire [2:0] retry_limit  = (overcurrent_retry_count_sel == `OCR_RETRY_ONE) ?
                            `OCR_RETRY_LIMIT_ONE : `OCR_RETRY_LIMIT_SEVEN;      // [R7]

  assign gate_drive = (state == ST_ON) && on_req;
  wire   oc_event   = gate_drive && trip_in;                                    // [R2]
  wire   retry_now  = (state == ST_COOL) && cool_expired;
  wire   flag_clear = reg_write && (reg_addr == `OCR_ADDR_LATCHED) &&
                      !reg_wdata[`OCR_BIT_OC_LATCHED];

  // retry state machine
  always @*
  begin
    next_state        = state;
    next_retries_used = retries_used;
    case (state)
      ST_ON:
      begin
        if (oc_event)
        begin
          if (overcurrent_retry_count_sel == `OCR_RETRY_NONE)
            next_state = ST_LATCHED;                                          // [R13]
          else if (!finite_retry)
            next_state = ST_COOL;                                             // [R23]
          else if (rst_running && retries_used >= retry_limit)
            next_state = ST_LATCHED;                                          // [R10]
          else
          begin
            next_state = ST_COOL;                                             // [R4]
            next_retries_used = rst_running ? retries_used + 3'h1 : 3'h1;     // [R9]
          end
        end
        else if (rst_expired)
          next_retries_used = 3'h0;                                           // [R9]
      end
      ST_COOL:
      begin
        if (cool_expired)
          next_state = ST_ON;                                                 // [R4]
      end
      ST_LATCHED:
      begin
        if (!overcurrent_latched_flag)
          next_state = ST_COOL;                                               // [R13]
      end
      default:
        next_state = ST_COOL;
    endcase
  end

  always @(posedge clock)
  begin
    if (srst)
    begin
      state        <= ST_ON;
      retries_used <= 3'h0;
    end
    else
    begin
      state        <= next_state;
      retries_used <= next_retries_used;                                      // [R12]
    end
  end

  // cooling delay timer
  ocr_timer u_cool_timer (
    .clock      (clock),
    .srst       (srst),
    .start      (next_state == ST_COOL && state != ST_COOL),
    .clear      (1'b0),
    .load_value (cool_cycles(cooldown_duration_sel)),                         // [R5]
    .running    (cool_running),
    .expired    (cool_expired)
  );

  // retry counter reset timer, own instance
  ocr_timer u_reset_timer (
    .clock      (clock),
    .srst       (srst),
    .start      (retry_now && finite_retry),                                  // [R8]
    .clear      (!pg || oc_event),                                            // [R11]
    .load_value (RESET_TIMER_CYCLES),
    .running    (rst_running),
    .expired    (rst_expired)
  );

  // flags: hardware set wins over software clear
  always @(posedge clock)
  begin
    if (srst)
    begin
      overcurrent_latched_flag <= 1'b0;
      overcurrent_present_flag <= 1'b0;
    end
    else
    begin
      if (oc_event)
        overcurrent_latched_flag <= 1'b1;                                     // [R2]
      else if (flag_clear)
        overcurrent_latched_flag <= 1'b0;
      overcurrent_present_flag <= cl_act && chg_in && gate_drive;             // [R1] [R3]
    end
  end

  // configuration registers and power-on default load
  always @(posedge clock)
  begin
    if (srst)
    begin
      retry_policy_control  <= `OCR_RST_RETRY_CTRL;
      limit_foldback_setup  <= `OCR_RST_STORED;
      delay_threshold_setup <= `OCR_RST_DELAY_SETUP;
      restart_delay_control <= `OCR_RST_RESTART;
      stored_limit_defaults <= `OCR_RST_STORED;
      defaults_pending      <= 1'b1;
    end
    else
    begin
      defaults_pending <= 1'b0;
      if (defaults_pending)
        limit_foldback_setup <= stored_limit_defaults;                        // [R15]
      else if (reg_write && reg_addr == `OCR_ADDR_LIMIT_SETUP)
        limit_foldback_setup <= reg_wdata;                                    // [R14] [R18]
      if (reg_write && reg_addr == `OCR_ADDR_RETRY_CTRL)
        retry_policy_control <= reg_wdata;
      if (reg_write && reg_addr == `OCR_ADDR_DELAY_SETUP)
        delay_threshold_setup <= reg_wdata;
      if (reg_write && reg_addr == `OCR_ADDR_RESTART)
        restart_delay_control <= reg_wdata;
      if (reg_write && reg_addr == `OCR_ADDR_STORED)
        stored_limit_defaults <= reg_wdata;
    end
  end

  // registered read data, unmapped reads zero
  always @(posedge clock)
  begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (reg_read)
    begin
      case (reg_addr)
        `OCR_ADDR_PRESENT:     reg_rdata <= {6'h00, overcurrent_present_flag, 1'b0};
        `OCR_ADDR_LATCHED:     reg_rdata <= {6'h00, overcurrent_latched_flag, 1'b0};
        `OCR_ADDR_RETRY_CTRL:  reg_rdata <= retry_policy_control;
        `OCR_ADDR_LIMIT_SETUP: reg_rdata <= limit_foldback_setup;
        `OCR_ADDR_DELAY_SETUP: reg_rdata <= delay_threshold_setup;
        `OCR_ADDR_RESTART:     reg_rdata <= {restart_delay_control[7], cool_running,
                                             restart_delay_control[5:0]};      // [R6]
        `OCR_ADDR_STORED:      reg_rdata <= stored_limit_defaults;
        default:               reg_rdata <= 8'h00;
      endcase
    end
  end

  // current limit and fast pull-down outputs
  wire [4:0] limit_mv = `OCR_LIMIT_BASE_MV + {1'b0, limit_sense_setting};     // [R14]
  wire [7:0] ratio    = fold_ratio(volt_b, floor_ratio(foldback_floor_sel), pg,
                                   normal_foldback_disable,
                                   load_power_foldback_enable);               // [R18]
  wire [12:0] scaled  = limit_mv * ratio;

  always @(posedge clock)
  begin
    if (srst)
    begin
      limit_sense_voltage     <= 13'h0000;
      fast_pulldown_threshold <= 6'h00;
    end
    else
    begin
      limit_sense_voltage     <= scaled;
      fast_pulldown_threshold <= {limit_mv, 1'b0};                            // [R16]
    end
  end

endmodule // ocr_ctrl

//--- include/ocr_defines.vh
`ifndef OCR_DEFINES_VH
`define OCR_DEFINES_VH

// register offsets
`define OCR_ADDR_PRESENT      8'h03
`define OCR_ADDR_LATCHED      8'h04
`define OCR_ADDR_RETRY_CTRL   8'h0B
`define OCR_ADDR_LIMIT_SETUP  8'h0D
`define OCR_ADDR_DELAY_SETUP  8'h0E
`define OCR_ADDR_RESTART      8'hA2
`define OCR_ADDR_STORED       8'hAD

// field positions
`define OCR_BIT_OC_PRESENT    1
`define OCR_BIT_OC_LATCHED    1
`define OCR_RETRY_SEL_LSB     0
`define OCR_LIMIT_SET_LSB     0
`define OCR_FLOOR_SEL_LSB     4
`define OCR_BIT_FOLD_OFF      6
`define OCR_BIT_LOAD_FOLD     7
`define OCR_COOL_SEL_LSB      0
`define OCR_BIT_DELAY_RUN     6

// reset values
`define OCR_RST_RETRY_CTRL    8'h03
`define OCR_RST_DELAY_SETUP   8'h00
`define OCR_RST_RESTART       8'h00
`define OCR_RST_STORED        8'h0F

// retry selector codes
`define OCR_RETRY_NONE        2'h0
`define OCR_RETRY_ONE         2'h1
`define OCR_RETRY_SEVEN       2'h2
`define OCR_RETRY_ALWAYS      2'h3
`define OCR_RETRY_LIMIT_ONE   3'h1
`define OCR_RETRY_LIMIT_SEVEN 3'h7

// foldback figures, ratio in 1/128 units, volts in 1.8V/255 codes
`define OCR_RATIO_FULL        8'h80
`define OCR_RATIO_10PCT       8'h0D
`define OCR_RATIO_20PCT       8'h1A
`define OCR_RATIO_50PCT       8'h40
`define OCR_KNEE_CODE         8'h80
`define OCR_LIMIT_BASE_MV     5'h0F

// timing
`define OCR_CLK_KHZ           25000
`define OCR_COOL_BASE_MS      512
`define OCR_RESET_TIMER_MS    16400
`define OCR_COOL_BASE_CYCLES  (`OCR_COOL_BASE_MS * `OCR_CLK_KHZ)
`define OCR_RESET_TIMER_CYCLES (`OCR_RESET_TIMER_MS * `OCR_CLK_KHZ)

`endif

//--- hdl/ocr_timer.v
`include "ocr_defines.vh"

// one-shot down counter with running level and expiry pulse
module ocr_timer (
  input  wire        clock,
  input  wire        srst,
  input  wire        start,
  input  wire        clear,
  input  wire [31:0] load_value,
  output reg         running,
  output reg         expired
);

  reg [31:0] remaining;

  // start restarts, clear wins over start
  always @(posedge clock)
  begin
    if (srst || clear)
    begin
      running   <= 1'b0;
      remaining <= 32'h00000000;
      expired   <= 1'b0;
    end
    else if (start)
    begin
      running   <= 1'b1;
      remaining <= load_value;
      expired   <= 1'b0;
    end
    else if (running && remaining <= 32'h00000001)
    begin
      running   <= 1'b0;
      remaining <= 32'h00000000;
      expired   <= 1'b1;
    end
    else
    begin
      remaining <= running ? remaining - 32'h00000001 : remaining;
      expired   <= 1'b0;
    end
  end

endmodule // ocr_timer

//--- test/ocr_fet_model.sv
// pass device, sense resistor and thermal timer network seen from the gate pin
module ocr_fet_model #(
  parameter int TRIP_CYCLES = 20
) (
  input  logic clock,
  input  logic gate_drive,
  input  logic overload,
  output logic current_limit_active,
  output logic thermal_timer_charging,
  output logic thermal_timer_tripped
);
  timeunit 1ns;
  timeprecision 1ns;
  int heat = 0;
  // loop limits only with the device on and a heavy load present
  assign current_limit_active   = gate_drive && overload;
  assign thermal_timer_charging = current_limit_active;
  assign thermal_timer_tripped  = heat >= TRIP_CYCLES;
  // node charges while limiting, discharges fully once the gate is off
  always @(posedge clock)
  begin
    if (current_limit_active)
      heat <= heat + 1;
    else if (!gate_drive)
      heat <= 0;
  end
endmodule // ocr_fet_model

//--- test/ocr_ctrl_assertions.sv
module ocr_chk #(
  parameter [31:0] COOL_BASE_CYCLES   = 32'h14,
  parameter [31:0] RESET_TIMER_CYCLES = 32'hC8
) (
  input wire        clock,
  input wire        srst,
  input wire        current_limit_active,
  input wire        thermal_timer_charging,
  input wire        thermal_timer_tripped,
  input wire [7:0]  reg_addr,
  input wire        reg_write,
  input wire        reg_read,
  input wire [7:0]  reg_rdata,
  input wire        gate_drive,
  input wire [12:0] limit_sense_voltage,
  input wire [5:0]  fast_pulldown_threshold
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0]  up_cnt;
  logic [31:0] off_cnt;
  logic        trip_seen;
  // settle count, gate-off length, trip seen since last turn-on
  always @(posedge clock)
  begin
    if (srst)
    begin
      up_cnt    <= 3'h0;
      off_cnt   <= 32'h0;
      trip_seen <= 1'b0;
    end
    else
    begin
      up_cnt  <= (up_cnt == 3'h4) ? up_cnt : up_cnt + 3'h1;
      off_cnt <= gate_drive ? 32'h0 : off_cnt + 32'h1;
      if (gate_drive && thermal_timer_tripped)
        trip_seen <= 1'b1;
      else if ($rose(gate_drive) || (reg_write && reg_addr == 8'h04))
        trip_seen <= 1'b0;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // held overload, and a status read
  sequence s_overload; (gate_drive && current_limit_active && thermal_timer_charging) [*5]; endsequence
  sequence s_rd(a); reg_read && reg_addr == a; endsequence
  property p_present_set; s_overload ##0 s_rd(8'h03) |=> reg_rdata[1]; endproperty
  a_present_set: assert property (p_present_set) else $error("present flag missing");
  property p_trip_off; gate_drive && thermal_timer_tripped |-> ##[1:4] !gate_drive; endproperty
  a_trip_off: assert property (p_trip_off) else $error("gate kept on after trip");
  property p_flag_set; trip_seen && off_cnt >= 32'h2 ##0 s_rd(8'h04) |=> reg_rdata[1]; endproperty
  a_flag_set: assert property (p_flag_set) else $error("fault flag missing");
  property p_present_clr; off_cnt >= 32'h3 ##0 s_rd(8'h03) |=> !reg_rdata[1]; endproperty
  a_present_clr: assert property (p_present_clr) else $error("present flag kept");
  property p_cool_min; $rose(gate_drive) && trip_seen |-> off_cnt >= COOL_BASE_CYCLES; endproperty
  a_cool_min: assert property (p_cool_min) else $error("retry before cooldown");
  property p_fast;
    up_cnt == 3'h4 |-> !fast_pulldown_threshold[0] && fast_pulldown_threshold >= 6'h1E
      && fast_pulldown_threshold <= 6'h3C;
  endproperty
  a_fast: assert property (p_fast) else $error("fast threshold off grid");
  property p_cap; up_cnt == 3'h4 |-> limit_sense_voltage <= {fast_pulldown_threshold, 6'h00}; endproperty
  a_cap: assert property (p_cap) else $error("limit above full scale");
  property p_floor;
    up_cnt == 3'h4 |-> {limit_sense_voltage, 1'b0} >= fast_pulldown_threshold * 14'h000D;
  endproperty
  a_floor: assert property (p_floor) else $error("limit below floor");
endmodule // ocr_chk

bind ocr_ctrl ocr_chk #(
  .COOL_BASE_CYCLES   (COOL_BASE_CYCLES),
  .RESET_TIMER_CYCLES (RESET_TIMER_CYCLES)
) ocr_chk_inst (
  .clock, .srst, .current_limit_active, .thermal_timer_charging, .thermal_timer_tripped,
  .reg_addr, .reg_write, .reg_read, .reg_rdata, .gate_drive, .limit_sense_voltage,
  .fast_pulldown_threshold
);

//--- test/testbench.sv
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int COOL = 20;
  logic        clock, srst, gate_on_request, power_good_latched, overload, reg_write;
  logic        reg_read, gate_drive, current_limit_active, thermal_timer_charging;
  logic        thermal_timer_tripped;
  logic [7:0]  attenuated_drain_sense, reg_addr, reg_wdata, reg_rdata, d;
  logic [12:0] limit_sense_voltage;
  logic [5:0]  fast_pulldown_threshold;
  int          bad_count = 0, n_checks = 0, cyc = 0;
  logic [7:0]  ra [8] = '{8'h0B, 8'h0D, 8'h0E, 8'hA2, 8'hAD, 8'h03, 8'h04, 8'h55};
  logic [7:0]  rv [8] = '{8'h03, 8'h0F, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h00, 8'h00};
  logic [7:0]  vs [5] = '{8'h00, 8'h40, 8'h80, 8'hC8, 8'hFF};

  ocr_ctrl #(.COOL_BASE_CYCLES(32'h14), .RESET_TIMER_CYCLES(32'hC8)) ocr_ctrl_inst (
    .clock, .srst, .gate_on_request, .current_limit_active, .thermal_timer_charging,
    .thermal_timer_tripped, .power_good_latched, .attenuated_drain_sense, .reg_addr,
    .reg_write, .reg_wdata, .reg_read, .reg_rdata, .gate_drive, .limit_sense_voltage,
    .fast_pulldown_threshold
  );
  ocr_fet_model #(.TRIP_CYCLES(20)) ocr_fet_model_inst (
    .clock, .gate_drive, .overload, .current_limit_active, .thermal_timer_charging,
    .thermal_timer_tripped
  );

  // 25 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // cycle count for off-time measurement
  always @(posedge clock) cyc <= cyc + 1;
  // hang guard, several times the expected run
  initial
  begin
    repeat (20000) @(posedge clock);
    bad_count++;
    report_and_stop();
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick;
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // limit outputs for one setup, mode and output voltage
  task automatic fold(input logic [7:0] cfg, input logic pg, input logic [7:0] v);
    logic [7:0] fl, r;
    fl = cfg[5:4] == 2'h0 ? 8'h0D : cfg[5:4] == 2'h1 ? 8'h1A : cfg[5:4] == 2'h2 ? 8'h40 : 8'h80;
    if (!pg)
      r = fl;
    else if (v <= 8'h80)
      r = cfg[6] ? 8'h80 : 8'(fl + ((16'(8'h80 - fl) * v) >> 7));
    else
      r = cfg[7] ? 8'(8'h80 - ((v - 8'h7F) >> 1)) : 8'h80;
    wr(8'h0D, cfg);
    power_good_latched     <= pg;
    attenuated_drain_sense <= v;
    repeat (6) @(posedge clock);
    #1 `CHK("limit", 13'((13'h00F + cfg[3:0]) * r), limit_sense_voltage)
    `CHK("fast", 6'(2 * (15 + cfg[3:0])), fast_pulldown_threshold)
  endtask
  // overload until the timer trips, then watch the off time
  task automatic trip(input logic retry, input int min_off);
    logic [7:0] v;
    int t0;
    @(posedge clock);
    overload <= 1'b1;
    repeat (8) @(posedge clock);
    rd(8'h03, v);
    `CHK("present", 1'b1, v[1])
    t0 = cyc;
    while (gate_drive !== 1'b0 && cyc - t0 < 100) tick();
    t0 = cyc;
    @(posedge clock);
    overload <= 1'b0;
    rd(8'h04, v);
    `CHK("latched", 1'b1, v[1])
    rd(8'h03, v);
    `CHK("present_off", 1'b0, v[1])
    rd(8'hA2, v);
    `CHK("delay_run", retry, v[6])
    while (gate_drive !== 1'b1 && cyc - t0 < min_off + 40) tick();
    `CHK("retried", retry, gate_drive)
    if (retry) `CHK("off_time", 1'b1, cyc - t0 >= min_off)
  endtask
  // host clears the fault; gate returns after one cooldown
  task automatic release_fault(input int min_off);
    int t0;
    wr(8'h04, 8'h00);
    t0 = cyc;
    while (gate_drive !== 1'b1 && cyc - t0 < min_off + 40) tick();
    `CHK("gate_back", 1'b1, gate_drive)
    `CHK("back_time", 1'b1, cyc - t0 >= min_off)
  endtask

  // main sequence
  initial
  begin
    srst = 1'b1;
    gate_on_request = 1'b0;
    power_good_latched = 1'b0;
    attenuated_drain_sense = 8'h00;
    reg_addr = 8'h00;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
    reg_read = 1'b0;
    overload = 1'b0;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    // host keeps its copper figure in the scratch area, which lives outside this block
    wr(8'hE9, 8'h5A);
    rd(8'hE9, d);
    `CHK("scratch", 8'h00, d)
    foreach (ra[i])
    begin
      rd(ra[i], d);
      `CHK("reset_value", rv[i], d)
    end
    for (int n = 0; n < 16; n++) fold(8'h30 | 8'(n), 1'b0, 8'h00);
    foreach (vs[j])
      for (int c = 0; c < 16; c++)
        for (int p = 0; p < 2; p++) fold(8'(c << 4), 1'(p), vs[j]);
    @(posedge clock);
    gate_on_request    <= 1'b1;
    power_good_latched <= 1'b1;
    for (int s = 1; s < 3; s++)
    begin
      wr(8'h0B, 8'(s));
      repeat (s == 1 ? 1 : 7) trip(1'b1, COOL);
      trip(1'b0, COOL);
      release_fault(COOL);
      repeat (300) @(posedge clock);
    end
    wr(8'h0B, 8'h01);
    trip(1'b1, COOL);
    repeat (300) @(posedge clock);
    trip(1'b1, COOL);
    trip(1'b0, COOL);
    release_fault(COOL);
    @(posedge clock);
    power_good_latched <= 1'b0;
    repeat (3) trip(1'b1, COOL);
    @(posedge clock);
    power_good_latched <= 1'b1;
    wr(8'h0E, 8'h02);
    wr(8'h0B, 8'h03);
    repeat (3) trip(1'b1, COOL * 4);
    wr(8'h0E, 8'h00);
    wr(8'h0B, 8'h00);
    trip(1'b0, COOL);
    release_fault(COOL);
    report_and_stop();
  end
endmodule // testbench
